// ### common/dfs_defines.svh
// Purpose: Offsets, field positions and fixed values of the sequencer.
// Assumes: Included by its bare name from the design; the package does not include it.
// Notes:   Definitions only.
`ifndef DFS_DEFINES_SVH
`define DFS_DEFINES_SVH

// Register byte offsets on the Avalon-MM slave.
`define DFS_CS_OFS     3'h0
`define DFS_DB_OFS     3'h4

// Field positions in command_status_reg.
`define DFS_CS_GO      0
`define DFS_CS_FN_LO   1
`define DFS_CS_FN_HI   3
`define DFS_CS_UNIT    4
`define DFS_CS_DONE    5
`define DFS_CS_IE      6
`define DFS_CS_TR      7
`define DFS_CS_DENS    8
`define DFS_CS_ERR     15

// Field positions in error_status_reg.
`define DFS_ES_CRC     0
`define DFS_ES_INIT    2
`define DFS_ES_PWR     3
`define DFS_ES_DENERR  4
`define DFS_ES_DRVDEN  5
`define DFS_ES_DD      6
`define DFS_ES_READY   7
`define DFS_ES_UNIT    8

// Fixed values used by the sequences.
`define DFS_CONFIRM    8'h49
`define DFS_CRC_INIT   16'hFFFF
`define DFS_CRC_POLY   16'h1021
`define DFS_RST_SECTOR 8'h01
`define DFS_RST_TRACK  8'h01
`define DFS_FMT_SECTOR 8'h01
`define DFS_FMT_TRACK  8'h00
`define DFS_DMA_STEP   16'h0002
`define DFS_DUMP_LAST  2'h3

// Error code that the sequencer raises itself; the value is arbitrary.
`define DFS_EC_CRC     8'h0C

`endif

// ### common/dfs_pkg.sv
// Purpose: Types shared by the diskette function sequencer.
// Assumes: Nothing beyond the defines header.
// Notes:   States, drive operations and carrier structs.
package dfs_pkg;

	// Sequencer states.
	typedef enum logic [3:0] {
		S_IDLE     = 4'h0,
		S_ARG_SEC  = 4'h1,
		S_ARG_TRK  = 4'h2,
		S_ARG_CONF = 4'h3,
		S_ARG_ADDR = 4'h4,
		S_DRIVE    = 4'h5,
		S_DUMP     = 4'h6,
		S_PWR_LOST = 4'h7,
		S_RESTORE  = 4'h8
	} dfs_state_t;

	// Operations requested from the drive subsystem.
	typedef enum logic [2:0] {
		OP_READ      = 3'h0,
		OP_WRITE     = 3'h1,
		OP_WRITE_DEL = 3'h2,
		OP_FORMAT    = 3'h3,
		OP_STATUS    = 3'h4,
		OP_RESTORE   = 3'h5
	} dfs_op_t;

	// Request held toward the drive until it answers.
	typedef struct packed {
		logic       valid;
		dfs_op_t    op;
		logic       unit;
		logic       density;
		logic [7:0] track;
		logic [7:0] sector;
	} dfs_drv_req_t;

	// One-cycle answer from the drive.
	typedef struct packed {
		logic       valid;
		logic       not_found;
		logic       density_err;
		logic       hdr_damaged;
		logic       deleted_mark;
		logic       ready;
		logic       disk_density;
		logic       head_load;
		logic [7:0] err_code;
	} dfs_drv_rsp_t;

	// Byte of a data field read from the disk.
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} dfs_rd_byte_t;

	// DMA word write toward memory.
	typedef struct packed {
		logic        valid;
		logic [15:0] addr;
		logic [15:0] data;
	} dfs_dma_t;

endpackage : dfs_pkg

// ### src/dfs_sequencer.sv
// Purpose: Function sequencer of a diskette controller interface.
// Assumes: Drive subsystem and DMA run on core_clk.
// Notes:   Registers reached over Avalon-MM with waitrequest.
`timescale 1ns/1ps
`default_nettype none
`include "dfs_defines.svh"

module dfs_sequencer
	import dfs_pkg::*;
(
	input  wire logic         core_clk,
	input  wire logic         rst_b,
	input  wire logic [2:0]   avs_address,
	input  wire logic         avs_read,
	input  wire logic         avs_write,
	input  wire logic [31:0]  avs_writedata,
	input  wire logic [3:0]   avs_byteenable,
	output logic [31:0]       avs_readdata,
	output logic              avs_waitrequest,
	output logic              irq,
	output dfs_drv_req_t      drv_req,
	input  wire dfs_drv_rsp_t drv_rsp,
	input  wire dfs_rd_byte_t rd_byte,
	output dfs_dma_t          dma,
	input  wire logic         dma_ack,
	input  wire logic         subsystem_power_loss
);

	// Whole state of the block in one record.
	typedef struct packed {
		dfs_state_t      st;
		logic            ack;
		logic [31:0]     rdata;
		logic            err;
		logic            dens;
		logic            tr;
		logic            ie;
		logic            done;
		logic            unit;
		logic [2:0]      func;
		logic [15:0]     es;
		logic [15:0]     db;
		logic [7:0]      sector;
		logic [7:0]      track;
		logic [1:0][7:0] cur_trk;
		logic [1:0]      drv_den;
		logic            head_load;
		logic [7:0]      err_code;
		logic [7:0]      wc;
		logic [15:0]     crc;
		logic [1:0]      word;
		logic            rst_rd;
		logic            pl1;
		logic            pl2;
		logic            pl3;
		logic            irq;
		dfs_drv_req_t    req;
		dfs_dma_t        dma;
	} dfs_regs_t;

	dfs_regs_t   q;       // Registered state.
	dfs_regs_t   next_q;  // Value for the next edge.
	logic        wr_cs;   // Write to command_status_reg taken.
	logic        wr_db;   // Write to data_buffer_reg taken.
	logic [15:0] wdat;    // Write data merged with byte lanes.
	logic [15:0] cs_view; // Read view of command_status_reg.
	logic [15:0] dump_w;  // Next word of the error code dump.

	// One byte step of the CCITT CRC, most significant bit first.
	function automatic logic [15:0] crc_step(input logic [15:0] c,
			input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {b, 8'h00};
		for (int i = 0; i < 8; i++) begin
			if (r[15]) begin
				r = {r[14:0], 1'b0} ^ `DFS_CRC_POLY;
			end else begin
				r = {r[14:0], 1'b0};
			end
		end
		return r;
	endfunction : crc_step

	// Slow registers answer one cycle after the request is seen.
	assign avs_waitrequest = (avs_read | avs_write) & ~q.ack;
	assign avs_readdata    = q.rdata;
	assign irq             = q.irq;
	assign drv_req         = q.req;
	assign dma             = q.dma;

	// Bus strobes, qualified by the answer cycle.
	assign wr_cs = q.ack & avs_write & (avs_address == `DFS_CS_OFS);
	assign wr_db = q.ack & avs_write & (avs_address == `DFS_DB_OFS);

	// Unwritten byte lanes keep the old data buffer bits.
	assign wdat = {avs_byteenable[1] ? avs_writedata[15:8] : q.db[15:8],
		avs_byteenable[0] ? avs_writedata[7:0] : q.db[7:0]};

	// Command and status as the host reads it; go reads zero.
	assign cs_view = {q.err, 6'h00, q.dens, q.tr, q.ie, q.done,
		q.unit, q.func, 1'b0};

	// Word after the one on offer; word one is loaded with the address.
	always_comb begin
		unique case (q.word)
			2'h0: dump_w = {q.cur_trk[1], q.cur_trk[0]};
			2'h1: dump_w = {q.sector, q.track};
			2'h2: dump_w = {q.cur_trk[q.unit], q.unit, q.drv_den[1],
				q.head_load, q.drv_den[0], 3'h0, q.dens};
			2'h3: dump_w = {q.wc, q.err_code};
		endcase
	end

	// Next-state logic for the bus, the sequencer and the pin.
	always_comb begin
		next_q = q;

		// The power pin crosses two flip-flops before use.
		next_q.pl1 = subsystem_power_loss;
		next_q.pl2 = q.pl1;
		next_q.pl3 = q.pl2;

		// Bus answer: capture read data, then release the slave.
		if (q.ack) begin
			next_q.ack = 1'b0;
		end else if (avs_read | avs_write) begin
			next_q.ack   = 1'b1;
			next_q.rdata = 32'h0000_0000;
			if (avs_address == `DFS_CS_OFS) begin
				next_q.rdata[15:0] = cs_view;
			end else if (avs_address == `DFS_DB_OFS) begin
				next_q.rdata[15:0] = q.db;
			end
		end

		// Interrupt enable may change at any time.
		if (wr_cs && avs_byteenable[0]) begin
			next_q.ie = avs_writedata[`DFS_CS_IE];
		end

		// The drive request drops once answered.
		if (drv_rsp.valid) begin
			next_q.req.valid = 1'b0;
		end

		unique case (q.st)
			// Wait for a function code while done stands.
			S_IDLE: begin
				if (wr_cs && q.done && (&avs_byteenable[1:0])) begin
					next_q.func = avs_writedata[`DFS_CS_FN_HI:`DFS_CS_FN_LO];
					next_q.unit = avs_writedata[`DFS_CS_UNIT];
					next_q.dens = avs_writedata[`DFS_CS_DENS];
					if (avs_writedata[`DFS_CS_GO]) begin
						next_q.err  = 1'b0;
						next_q.done = 1'b0;
						unique case (next_q.func)
							// Read and both writes take two arguments.
							3'h2, 3'h3, 3'h6: begin
								next_q.es = 16'h0000;
								next_q.tr = 1'b1;
								next_q.st = S_ARG_SEC;
							end
							// Set density needs a confirm character.
							3'h4: begin
								next_q.es = 16'h0000;
								next_q.tr = 1'b1;
								next_q.st = S_ARG_CONF;
							end
							// Read status goes straight to the drive.
							3'h5: begin
								next_q.req = '{1'b1, OP_STATUS, next_q.unit,
									next_q.dens, q.track, q.sector};
								next_q.st  = S_DRIVE;
							end
							// Error code dump first takes an address.
							3'h7: begin
								next_q.tr = 1'b1;
								next_q.st = S_ARG_ADDR;
							end
							// Buffer moves are not handled by this block.
							default: begin
								next_q.db   = q.es;
								next_q.done = 1'b1;
							end
						endcase
					end
				end
			end

			// Sector address arrives while the request stands.
			S_ARG_SEC: begin
				if (wr_db && q.tr) begin
					next_q.db     = wdat;
					next_q.sector = wdat[7:0];
					next_q.tr     = 1'b0;
					next_q.st     = S_ARG_TRK;
				end
			end

			// Track address; the request stays low while seeking.
			S_ARG_TRK: begin
				if (wr_db && q.tr) begin
					next_q.db      = wdat;
					next_q.track   = wdat[7:0];
					next_q.tr      = 1'b0;
					next_q.crc     = `DFS_CRC_INIT;
					next_q.req     = '{1'b1, OP_READ, q.unit, q.dens,
						wdat[7:0], q.sector};
					if (q.func == 3'h2) begin
						next_q.req.op = OP_WRITE;
					end else if (q.func == 3'h6) begin
						next_q.req.op = OP_WRITE_DEL;
					end
					next_q.st      = S_DRIVE;
				end else begin
					// The request comes back one cycle after the sector.
					next_q.tr = 1'b1;
				end
			end

			// Only the confirm character starts a reformat.
			S_ARG_CONF: begin
				if (wr_db && q.tr) begin
					next_q.db = wdat;
					if (wdat[7:0] == `DFS_CONFIRM) begin
						next_q.tr  = 1'b0;
						next_q.req = '{1'b1, OP_FORMAT, q.unit, q.dens,
							`DFS_FMT_TRACK, `DFS_FMT_SECTOR};
						next_q.st  = S_DRIVE;
					end
				end
			end

			// Memory address for the dump.
			S_ARG_ADDR: begin
				if (wr_db && q.tr) begin
					next_q.db   = wdat;
					next_q.tr   = 1'b0;
					next_q.word = 2'h0;
					next_q.dma  = '{1'b1, wdat, {q.wc, q.err_code}};
					next_q.st   = S_DUMP;
				end
			end

			// Drive busy; read bytes feed the CRC as they arrive.
			S_DRIVE: begin
				if (rd_byte.valid && q.req.op == OP_READ) begin
					next_q.crc = crc_step(q.crc, rd_byte.data);
				end
				if (drv_rsp.valid) begin
					next_q.done      = 1'b1;
					next_q.head_load = drv_rsp.head_load;
					next_q.es[`DFS_ES_UNIT] = q.unit;
					next_q.es[`DFS_ES_DRVDEN] = drv_rsp.disk_density;
					next_q.drv_den[q.unit] = drv_rsp.disk_density;
					if (q.req.op == OP_STATUS) begin
						next_q.es[`DFS_ES_READY] = drv_rsp.ready;
					end else if (q.req.op == OP_FORMAT) begin
						if (drv_rsp.hdr_damaged) begin
							next_q.err      = 1'b1;
							next_q.err_code = drv_rsp.err_code;
						end else begin
							next_q.drv_den[q.unit] = q.dens;
						end
					end else if (drv_rsp.not_found) begin
						next_q.err      = 1'b1;
						next_q.err_code = drv_rsp.err_code;
					end else if (drv_rsp.density_err) begin
						next_q.es[`DFS_ES_DENERR] = 1'b1;
						next_q.err      = 1'b1;
						next_q.err_code = drv_rsp.err_code;
					end else begin
						next_q.cur_trk[q.unit] = q.track;
						if (q.req.op == OP_READ) begin
							next_q.es[`DFS_ES_DD] = drv_rsp.deleted_mark;
							if (next_q.crc != 16'h0000) begin
								next_q.es[`DFS_ES_CRC] = 1'b1;
								next_q.err      = 1'b1;
								next_q.err_code = `DFS_EC_CRC;
							end
						end
					end
					// Every ending leaves the status in the data buffer.
					next_q.db = next_q.es;
					next_q.st = S_IDLE;
				end
			end

			// Next word loads only on acceptance, so the offer never moves.
			S_DUMP: begin
				if (dma_ack) begin
					next_q.dma.data = dump_w;
					next_q.dma.addr = 16'(q.dma.addr + `DFS_DMA_STEP);
					next_q.word     = 2'(q.word + 2'h1);
					if (q.word == `DFS_DUMP_LAST) begin
						next_q.dma.valid = 1'b0;
						next_q.done      = 1'b1;
						next_q.st        = S_IDLE;
					end
				end
			end

			// Power gone: wait for it to come back.
			S_PWR_LOST: begin
				next_q.st = S_PWR_LOST;
			end

			// Home the heads, then read the check sector.
			S_RESTORE: begin
				if (drv_rsp.valid && !q.rst_rd) begin
					next_q.cur_trk = '0;
					next_q.rst_rd  = 1'b1;
					next_q.req     = '{1'b1, OP_READ, 1'b0, q.dens,
						`DFS_RST_TRACK, `DFS_RST_SECTOR};
				end else if (drv_rsp.valid) begin
					next_q.rst_rd = 1'b0;
					next_q.es[`DFS_ES_INIT] = 1'b1;
					next_q.db   = next_q.es;
					next_q.done = 1'b1;
					next_q.st   = S_IDLE;
				end
			end

			// Unused codes fall back to the idle state.
			default: begin
				next_q.st = S_IDLE;
			end
		endcase

		// Power loss overrides any sequence in flight.
		if (q.pl2 && !q.pl3) begin
			next_q.req.valid = 1'b0;
			next_q.dma.valid = 1'b0;
			next_q.tr        = 1'b0;
			next_q.done      = 1'b1;
			next_q.err       = 1'b1;
			next_q.es[`DFS_ES_PWR] = 1'b1;
			next_q.db        = next_q.es;
			next_q.st        = S_PWR_LOST;
		end else if (!q.pl2 && q.pl3) begin
			// Return of power clears errors and restarts the drive.
			next_q.done   = 1'b0;
			next_q.err    = 1'b0;
			next_q.es     = 16'h0000;
			next_q.rst_rd = 1'b0;
			next_q.req    = '{1'b1, OP_RESTORE, 1'b0, q.dens,
				`DFS_FMT_TRACK, `DFS_FMT_SECTOR};
			next_q.st     = S_RESTORE;
		end

		// The interrupt request follows done and the enable.
		next_q.irq = next_q.ie & next_q.done;
	end

	// State register; reset starts the restore sequence.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			q           <= '0;
			q.st        <= S_RESTORE;
			q.req.valid <= 1'b1;
			q.req.op    <= OP_RESTORE;
		end else begin
			q <= next_q;
		end
	end

endmodule : dfs_sequencer
`default_nettype wire

// ### bench/dfs_sequencer_props.sv
// Purpose: Concurrent checks on the sequencer's drive, DMA and bus ports.
// Assumes: One clock domain, reset rst_b active low.
// Notes:   Bound from the testbench top file.
`timescale 1ns/1ps
`default_nettype none
module dfs_sequencer_props
	import dfs_pkg::*;
(
	input wire logic         core_clk,
	input wire logic         rst_b,
	input wire logic         avs_read,
	input wire logic         avs_write,
	input wire logic         avs_waitrequest,
	input wire logic         irq,
	input wire dfs_drv_req_t drv_req,
	input wire dfs_drv_rsp_t drv_rsp,
	input wire dfs_dma_t     dma,
	input wire logic         dma_ack,
	input wire logic         subsystem_power_loss
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// The drive answers the restore step.
	sequence s_restore_ans;
		drv_req.valid && drv_req.op == OP_RESTORE && drv_rsp.valid;
	endsequence
	// The check read of sector 1, track 1, drive 0 follows.
	sequence s_check_read;
		drv_req.valid && drv_req.op == OP_READ && !drv_req.unit &&
			drv_req.track == 8'h01 && drv_req.sector == 8'h01;
	endsequence
	property p_wait_one;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	// A power loss may abort a request, so it is left out here.
	property p_req_hold;
		disable iff (!rst_b || subsystem_power_loss)
		drv_req.valid && !drv_rsp.valid |=> drv_req.valid && $stable(drv_req);
	endproperty
	// A restore answer chains straight into the check read instead.
	property p_req_drop;
		drv_req.valid && drv_rsp.valid && drv_req.op != OP_RESTORE |=>
			!drv_req.valid;
	endproperty
	property p_seek_no_irq;
		drv_req.valid [*2] |-> !irq;
	endproperty
	property p_dma_hold;
		dma.valid && !dma_ack |=> dma.valid && $stable(dma.addr) &&
			$stable(dma.data);
	endproperty
	property p_dma_no_irq;
		dma.valid [*2] |-> !irq;
	endproperty
	property p_restore;
		$rose(rst_b) |-> drv_req.valid && drv_req.op == OP_RESTORE;
	endproperty
	property p_pwr_abort;
		subsystem_power_loss [*6] |-> !drv_req.valid && !dma.valid;
	endproperty
	property p_restore_chain;
		s_restore_ans |-> ##[1:4] s_check_read;
	endproperty
	a_wait_one: assert property (p_wait_one)
		else $error("bus wait longer than one cycle");
	a_req_hold: assert property (p_req_hold)
		else $error("drive request changed before answer");
	a_req_drop: assert property (p_req_drop)
		else $error("drive request kept after answer");
	a_seek_no_irq: assert property (p_seek_no_irq)
		else $error("interrupt while drive busy");
	a_dma_hold: assert property (p_dma_hold)
		else $error("dma word changed before ack");
	a_dma_no_irq: assert property (p_dma_no_irq)
		else $error("interrupt during dump");
	a_restore: assert property (p_restore)
		else $error("no restore after reset");
	a_pwr_abort: assert property (p_pwr_abort)
		else $error("activity during power loss");
	a_restore_chain: assert property (p_restore_chain)
		else $error("no check read after restore");
endmodule : dfs_sequencer_props
`default_nettype wire

// ### bench/dfs_drive_model.sv
// Purpose: Drive subsystem and DMA memory beside the sequencer.
// Assumes: Same clock; mode picks the drive's answer to each request.
// Notes:   Modes 0 clean, 1 not found, 2 density, 3 bad CRC, 4 deleted.
`timescale 1ns/1ps
`default_nettype none
module dfs_drive_model
	import dfs_pkg::*;
(
	input  wire logic         core_clk,
	input  wire logic         rst_b,
	input  wire dfs_drv_req_t drv_req,
	input  wire logic [2:0]   mode,
	output dfs_drv_rsp_t      drv_rsp,
	output dfs_rd_byte_t      rd_byte,
	output dfs_drv_req_t      last,
	input  wire dfs_dma_t     dma,
	output logic              dma_ack
);
	logic [15:0] mem [0:3]; // Words stored by the dump.
	logic [15:0] crc;       // Running CRC of the sent data field.
	logic [7:0]  b;         // Byte being sent.
	logic [1:0]  cnt;       // Memory latency count.
	function automatic logic [15:0] step(input logic [15:0] c,
		input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {d, 8'h00};
		for (int k = 0; k < 8; k++)
			r = r[15] ? {r[14:0], 1'b0} ^ 16'h1021 : {r[14:0], 1'b0};
		return r;
	endfunction : step
	initial begin
		drv_rsp = '0;
		rd_byte = '0;
		last = '0;
		dma_ack = 1'b0;
		cnt = 2'h0;
	end
	// One request at a time; a restore is quick, other seeks are slow.
	always begin
		@(posedge core_clk);
		if (rst_b === 1'b1 && drv_req.valid === 1'b1) begin
			last <= drv_req;
			repeat ((drv_req.op == OP_RESTORE) ? 2 : 20) @(posedge core_clk);
			if (last.op == OP_READ && mode != 3'h1 && mode != 3'h2) begin
				crc = 16'hFFFF;
				// Data field, then its CRC msb first, so the residue is zero.
				for (int i = 0; i < 6; i++) begin
					b = (i == 4) ? crc[15:8] : (i == 5) ? crc[7:0] : 8'h5A + 8'(i);
					if (i == 4 && mode == 3'h3)
						b = ~b;
					if (i < 4)
						crc = step(crc, b);
					rd_byte <= {1'b1, b};
					@(posedge core_clk);
				end
				// The data line does not keep its last value once released.
				rd_byte <= {1'b0, ~b};
			end
			drv_rsp <= {1'b1, mode == 3'h1, mode == 3'h2, 1'b0, mode == 3'h4,
				1'b1, last.density ^ (mode == 3'h2), 1'b1, 8'h00};
			@(posedge core_clk);
			drv_rsp <= '0;
			@(posedge core_clk);
		end
	end
	// Memory takes each DMA word after a short delay.
	always @(posedge core_clk) begin
		dma_ack <= 1'b0;
		if (dma.valid === 1'b1 && !dma_ack) begin
			cnt <= cnt + 2'h1;
			if (cnt == 2'h2) begin
				dma_ack <= 1'b1;
				mem[dma.addr[2:1]] <= dma.data;
				cnt <= 2'h0;
			end
		end
	end
endmodule : dfs_drive_model
`default_nettype wire

// ### bench/tb_top.sv
// Purpose: Directed scenarios for the diskette function sequencer.
// Assumes: Drive model answers every request; memory acks every word.
// Notes:   Host waits for done before loading a function, except the go write made during each read.
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import dfs_pkg::*;
;
	logic         core_clk, rst_b, avs_read, avs_write, irq, dma_ack;
	logic         avs_waitrequest, subsystem_power_loss;
	logic [2:0]   avs_address, mode;
	logic [31:0]  avs_writedata, avs_readdata;
	logic [15:0]  q;
	dfs_drv_req_t drv_req, last;
	dfs_drv_rsp_t drv_rsp;
	dfs_rd_byte_t rd_byte;
	dfs_dma_t     dma;
	int           num_errors, checked;
	dfs_sequencer dfs_sequencer_inst (.core_clk(core_clk), .rst_b(rst_b),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irq(irq), .drv_req(drv_req),
		.drv_rsp(drv_rsp), .rd_byte(rd_byte), .dma(dma), .dma_ack(dma_ack),
		.subsystem_power_loss(subsystem_power_loss));
	dfs_drive_model dfs_drive_model_inst (.core_clk(core_clk), .rst_b(rst_b),
		.drv_req(drv_req), .mode(mode), .drv_rsp(drv_rsp), .rd_byte(rd_byte),
		.last(last), .dma(dma), .dma_ack(dma_ack));
	always #5 core_clk = ~core_clk;
	task automatic end_of_test;
		$display("Comparisons %0d, mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test
	task automatic hang;
		num_errors++;
		$display("ERROR wait expected 1 seen 0");
		end_of_test;
	endtask : hang
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		checked++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// One Avalon access, held until waitrequest is sampled low.
	task automatic bus(input logic w, input logic [2:0] a,
		input logic [15:0] d);
		int n;
		avs_write <= w;
		avs_read <= ~w;
		avs_address <= a;
		avs_writedata <= {16'h0000, d};
		n = 0;
		// Settled values are looked at mid-cycle, before the next edge.
		@(negedge core_clk);
		while (avs_waitrequest !== 1'b0) begin
			n++;
			if (n > 20)
				hang;
			@(negedge core_clk);
		end
		q = avs_readdata[15:0];
		// The access completes at this edge; only then is it released.
		@(posedge core_clk);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge core_clk);
	endtask : bus
	// Polls the command register until bit b is set.
	task automatic wait_bit(input int b);
		for (int n = 0; n < 200; n++) begin
			bus(1'b0, 3'h0, 16'h0000);
			if (q[b] === 1'b1)
				return;
		end
		hang;
	endtask : wait_bit
	task automatic arg(input logic [15:0] d);
		wait_bit(7);
		bus(1'b1, 3'h4, d);
	endtask : arg
	task automatic t_restore;
		wait_bit(5);
		chk("rst_cs", 16'h0020, q & 16'h8020);
		chk("rst_at", 16'h0101, {last.track, last.sector});
		bus(1'b0, 3'h4, 16'h0000);
		chk("rst_es", 16'h0004, q & 16'h0004);
		$display("restore test done");
	endtask : t_restore
	task automatic t_read;
		logic [15:0] es_x [0:4];
		logic        er_x [0:4];
		es_x = '{16'h0000, 16'h0000, 16'h0010, 16'h0001, 16'h0040};
		er_x = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
		for (int m = 0; m < 5; m++) begin
			mode <= 3'(m);
			bus(1'b1, 3'h0, 16'h0047);
			bus(1'b0, 3'h0, 16'h0000);
			chk("rd_start", 16'h0080, q & 16'h80A0);
			arg(16'h0005);
			arg(16'h0009);
			bus(1'b1, 3'h0, 16'h004F);
			bus(1'b0, 3'h0, 16'h0000);
			chk("seek", 16'h0000, q & 16'h00A0);
			wait_bit(5);
			chk("rd_cs", {er_x[m], 15'h0026}, q & 16'h802E);
			chk("rd_irq", 16'h0001, {15'h0000, irq});
			chk("rd_at", 16'h0905, {last.track, last.sector});
			bus(1'b0, 3'h4, 16'h0000);
			chk("rd_es", es_x[m], q & 16'h0051);
		end
		mode <= 3'h0;
		$display("read sector test done");
	endtask : t_read
	task automatic t_density;
		bus(1'b1, 3'h0, 16'h0149);
		arg(16'h0000);
		bus(1'b0, 3'h0, 16'h0000);
		chk("conf", 16'h0080, q & 16'h00A0);
		bus(1'b1, 3'h4, 16'h0049);
		wait_bit(5);
		chk("fmt_at", 16'h0001, {last.track, last.sector});
		chk("fmt_op", {12'h000, OP_FORMAT, 1'b1},
			{12'h000, last.op, last.density});
		chk("fmt_irq", 16'h0001, {15'h0000, irq});
		$display("density test done");
	endtask : t_density
	task automatic t_misc;
		bus(1'b1, 3'h0, 16'h000B);
		wait_bit(5);
		bus(1'b0, 3'h4, 16'h0000);
		chk("ready", 16'h0080, q & 16'h0080);
		bus(1'b1, 3'h0, 16'h000D);
		arg(16'h0003);
		arg(16'h0004);
		wait_bit(5);
		chk("wdel", {13'h0000, OP_WRITE_DEL}, {13'h0000, last.op});
		bus(1'b1, 3'h0, 16'h010F);
		arg(16'h0100);
		wait_bit(5);
		chk("w1", 16'h000C, dfs_drive_model_inst.mem[0]);
		chk("w2", 16'h0004, dfs_drive_model_inst.mem[1]);
		chk("w3", 16'h0304, dfs_drive_model_inst.mem[2]);
		chk("w4", 16'h0421, dfs_drive_model_inst.mem[3]);
		$display("status, deleted write and dump test done");
	endtask : t_misc
	task automatic t_power;
		subsystem_power_loss <= 1'b1;
		repeat (10) @(posedge core_clk);
		bus(1'b0, 3'h0, 16'h0000);
		chk("pwr_cs", 16'h8020, q & 16'h8020);
		bus(1'b0, 3'h4, 16'h0000);
		chk("pwr_es", 16'h0008, q & 16'h0008);
		subsystem_power_loss <= 1'b0;
		repeat (6) @(posedge core_clk);
		wait_bit(5);
		chk("back_cs", 16'h0020, q & 16'h8020);
		bus(1'b0, 3'h4, 16'h0000);
		chk("back_es", 16'h0004, q & 16'h000C);
		bus(1'b1, 3'h0, 16'h0005);
		arg(16'h0007);
		arg(16'h0002);
		wait_bit(5);
		chk("stale_wr", {13'h0000, OP_WRITE}, {13'h0000, last.op});
		$display("power test done");
	endtask : t_power
	initial begin
		core_clk = 1'b0;
		rst_b = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 3'h0;
		avs_writedata = 32'h00000000;
		subsystem_power_loss = 1'b0;
		mode = 3'h0;
		num_errors = 0;
		checked = 0;
		repeat (8) @(posedge core_clk);
		rst_b <= 1'b1;
		@(posedge core_clk);
		t_restore;
		t_read;
		t_density;
		t_misc;
		t_power;
		end_of_test;
	end
endmodule : tb_top
bind dfs_sequencer dfs_sequencer_props dfs_sequencer_props_inst (
	.core_clk(core_clk), .rst_b(rst_b), .avs_read(avs_read),
	.avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .irq(irq),
	.drv_req(drv_req), .drv_rsp(drv_rsp), .dma(dma), .dma_ack(dma_ack),
	.subsystem_power_loss(subsystem_power_loss));
`default_nettype wire
